// ### shared/ddr2_pins_pkg.sv
`default_nettype none
// How it works
// - cke registered high turns internal clocking on, registered low off.
// - cke low enters precharge power-down or self refresh, else active one.
// - cke is sampled on clock edges for power-down and self-refresh entry.
// - self-refresh exit is seen from cke alone, with no clock edge.
// - power-down keeps only clock pair, cke and termination inputs alive.
// - self refresh keeps only the cke input alive.
// - a low cke is recognised from power-up; controller holds it low.
// - chip select low enables the decoder; high masks every command.
// - chip select, row, column strobe and write enable form the command.
// - write mask sampled on both strobe edges; masked data is not stored.
// - lower mask governs data 7:0, upper mask 15:8; masks are inputs.
// - termination control registered high switches termination on.
// - termination applies only to data, strobe and mask pins of the width.
// - termination control is ignored when disabled by mode load.
// - the data bus is bidirectional, sixteen bits wide here.
// - inputs are sampled where true clock rises and complement falls.
// - read strobe is edge aligned with data; write strobe centre aligned.
package ddr2_pins_pkg;
  localparam int DQ_W      = 16;
  localparam int BYTE_W    = 8;
  localparam int LANES     = 2;
  localparam int BURST     = 4;
  localparam int BANKS     = 4;
  localparam int ADDR_W    = 13;
  localparam int BA_W      = 2;
  localparam int SYNC_W    = 43;
  localparam int TERM_PINS = 20;
  localparam int RTT_BIT0    = 2;
  localparam int RTT_BIT1    = 6;
  localparam int PRE_ALL_BIT = 10;
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [1:0] EMR_BANK  = 2'h1;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [2:0] RD_LAST   = 3'h4;
  localparam logic       TERM_RST  = 1'h0;
  typedef enum logic [3:0] {
    ST_ACTIVE   = 4'h1,
    ST_PD_PRE   = 4'h2,
    ST_PD_ACT   = 4'h4,
    ST_SELF_REF = 4'h8
  } pwr_state_t;
endpackage
`default_nettype wire

// ### rtl/ddr2_data_lane.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_data_lane (
  input  wire logic                                  ref_clk,
  input  wire logic                                  nrst,
  input  wire logic                                  wr_go,
  input  wire logic                                  rd_go,
  input  wire logic                                  ck_edge,
  input  wire logic                                  buf_en,
  input  wire logic [ddr2_pins_pkg::LANES-1:0]       dqs_s,
  input  wire logic [ddr2_pins_pkg::DQ_W-1:0]        dq_s,
  input  wire logic [ddr2_pins_pkg::LANES-1:0]       mask_s,
  output logic      [ddr2_pins_pkg::DQ_W-1:0]        dq_out,
  output logic      [ddr2_pins_pkg::DQ_W-1:0]        dq_oe,
  output logic      [ddr2_pins_pkg::LANES-1:0]       dqs_out,
  output logic      [ddr2_pins_pkg::LANES-1:0]       dqs_oe,
  output logic      [ddr2_pins_pkg::BURST*16-1:0]    wr_data,
  output logic      [ddr2_pins_pkg::BURST*2-1:0]     wr_byte_en,
  output logic                                       wr_done
);
  import ddr2_pins_pkg::*;
  logic                          wr_busy_ff, nxt_wr_busy;
  logic [1:0]                    wr_beat_ff, nxt_wr_beat;
  logic                          wr_done_ff, nxt_wr_done;
  logic                          dqs_q_ff;
  logic                          rd_busy_ff, nxt_rd_busy;
  logic [2:0]                    rd_cnt_ff, nxt_rd_cnt;
  logic [DQ_W-1:0]               dq_out_ff, nxt_dq_out;
  logic                          dq_oe_ff, nxt_dq_oe;
  logic [LANES-1:0]              dqs_out_ff, nxt_dqs_out;
  logic [LANES-1:0]              dqs_oe_ff, nxt_dqs_oe;
  logic [BURST-1:0][DQ_W-1:0]    word_w;
  logic [BURST*LANES-1:0]        en_w;
  logic                          wr_edge;

  // every toggle of the lower strobe is a beat, so both edges carry data and mask
  assign wr_edge = wr_busy_ff & buf_en & (dqs_s[0] != dqs_q_ff);

  genvar g;
  generate
    for (g = 0; g < BURST*LANES; g++) begin : g_byte
      localparam int L = g % LANES;
      localparam int B = g / LANES;
      logic [BYTE_W-1:0] byte_ff, nxt_byte;
      logic              en_ff, nxt_en;
      always_comb begin
        nxt_byte = byte_ff;
        nxt_en   = en_ff;
        if (wr_go) begin
          nxt_en = 1'h0;
        end
        if (wr_edge && wr_beat_ff == 2'(B) && !mask_s[L]) begin
          nxt_byte = dq_s[L*BYTE_W +: BYTE_W];
          nxt_en   = 1'h1;
        end
      end
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          byte_ff <= 8'h00;
          en_ff   <= 1'h0;
        end else begin
          byte_ff <= nxt_byte;
          en_ff   <= nxt_en;
        end
      end
      assign word_w[B][L*BYTE_W +: BYTE_W] = byte_ff;
      assign en_w[g] = en_ff;
    end
  endgenerate

  always_comb begin
    nxt_wr_busy = wr_busy_ff;
    nxt_wr_beat = wr_beat_ff;
    nxt_wr_done = 1'h0;
    nxt_rd_busy = rd_busy_ff;
    nxt_rd_cnt  = rd_cnt_ff;
    nxt_dq_out  = dq_out_ff;
    nxt_dq_oe   = dq_oe_ff;
    nxt_dqs_out = dqs_out_ff;
    nxt_dqs_oe  = dqs_oe_ff;
    if (wr_go && !rd_busy_ff) begin
      nxt_wr_busy = 1'h1;
      nxt_wr_beat = 2'h0;
    end else if (wr_edge) begin
      nxt_wr_beat = wr_beat_ff + 2'h1;
      if (wr_beat_ff == BEAT_LAST) begin
        nxt_wr_busy = 1'h0;
        nxt_wr_done = 1'h1;
      end
    end
    if (rd_go && !wr_busy_ff) begin
      nxt_rd_busy = 1'h1;
      nxt_rd_cnt  = 3'h0;
    end else if (rd_busy_ff && ck_edge) begin
      if (rd_cnt_ff == RD_LAST) begin
        nxt_rd_busy = 1'h0;
        nxt_dq_oe   = 1'h0;
        nxt_dqs_oe  = 2'h0;
        nxt_dqs_out = 2'h0;
      end else begin
        // data and strobe change in one cycle: edge aligned
        nxt_dq_out  = word_w[rd_cnt_ff[1:0]];
        nxt_dq_oe   = 1'h1;
        nxt_dqs_out = {LANES{~rd_cnt_ff[0]}};
        nxt_dqs_oe  = 2'h3;
        nxt_rd_cnt  = rd_cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_busy_ff <= 1'h0;
      wr_beat_ff <= 2'h0;
      wr_done_ff <= 1'h0;
      dqs_q_ff   <= 1'h0;
      rd_busy_ff <= 1'h0;
      rd_cnt_ff  <= 3'h0;
      dq_out_ff  <= 16'h0000;
      dq_oe_ff   <= 1'h0;
      dqs_out_ff <= 2'h0;
      dqs_oe_ff  <= 2'h0;
    end else begin
      wr_busy_ff <= nxt_wr_busy;
      wr_beat_ff <= nxt_wr_beat;
      wr_done_ff <= nxt_wr_done;
      dqs_q_ff   <= dqs_s[0];
      rd_busy_ff <= nxt_rd_busy;
      rd_cnt_ff  <= nxt_rd_cnt;
      dq_out_ff  <= nxt_dq_out;
      dq_oe_ff   <= nxt_dq_oe;
      dqs_out_ff <= nxt_dqs_out;
      dqs_oe_ff  <= nxt_dqs_oe;
    end
  end

  assign dq_out     = dq_out_ff;
  assign dq_oe      = {DQ_W{dq_oe_ff}};
  assign dqs_out    = dqs_out_ff;
  assign dqs_oe     = dqs_oe_ff;
  assign wr_data    = word_w;
  assign wr_byte_en = en_w;
  assign wr_done    = wr_done_ff;

  a_mask_keeps: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    wr_edge && mask_s[0] && wr_beat_ff == 2'h1 |=> $stable(word_w[1][7:0]))
    else $error("masked lower byte was stored");
  a_lane_upper: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    wr_edge && !mask_s[1] && wr_beat_ff == 2'h0
    |=> word_w[0][15:8] == $past(dq_s[15:8]) && en_w[1])
    else $error("upper mask lane stored wrong byte");
  a_rd_aligned: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    $rose(dq_oe_ff) |-> dqs_oe_ff == 2'h3 && dqs_out_ff == 2'h3
    ##1 (!ck_edge || !rd_busy_ff)[*1])
    else $error("read strobe not edge aligned with data");
endmodule // ddr2_data_lane
`default_nettype wire

// ### rtl/ddr2_ctrl_pins.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_pins (
  input  wire logic                                ref_clk,
  input  wire logic                                nrst,
  input  wire logic                                ck,
  input  wire logic                                clock_complement,
  input  wire logic                                cke,
  input  wire logic                                cs_n,
  input  wire logic                                ras_n,
  input  wire logic                                cas_n,
  input  wire logic                                we_n,
  input  wire logic [ddr2_pins_pkg::BA_W-1:0]      ba,
  input  wire logic [ddr2_pins_pkg::ADDR_W-1:0]    addr,
  input  wire logic                                termination_control,
  input  wire logic                                lower_write_mask,
  input  wire logic                                upper_write_mask,
  input  wire logic [ddr2_pins_pkg::DQ_W-1:0]      dq_in,
  output logic      [ddr2_pins_pkg::DQ_W-1:0]      dq_out,
  output logic      [ddr2_pins_pkg::DQ_W-1:0]      dq_oe,
  input  wire logic [ddr2_pins_pkg::LANES-1:0]     dqs_in,
  output logic      [ddr2_pins_pkg::LANES-1:0]     dqs_out,
  output logic      [ddr2_pins_pkg::LANES-1:0]     dqs_oe,
  output var ddr2_pins_pkg::pwr_state_t            pwr_state,
  output logic                                     clocking_on,
  output logic                                     cmd_buf_en,
  output logic                                     ck_buf_en,
  output logic                                     term_buf_en,
  output logic      [ddr2_pins_pkg::TERM_PINS-1:0] term_pin_en,
  output logic                                     cmd_valid,
  output logic      [3:0]                          cmd_code,
  output logic      [ddr2_pins_pkg::BANKS-1:0]     bank_open,
  output logic      [ddr2_pins_pkg::BURST*16-1:0]  wr_data,
  output logic      [ddr2_pins_pkg::BURST*2-1:0]   wr_byte_en,
  output logic                                     wr_done
);
  import ddr2_pins_pkg::*;
  logic [SYNC_W-1:0]  s1_ff, s2_ff;
  logic               ck_s, cn_s, cke_s, cs_s, ras_s, cas_s, we_s, term_s;
  logic [BA_W-1:0]    ba_s;
  logic [ADDR_W-1:0]  addr_s;
  logic [LANES-1:0]   mask_s, dqs_s;
  logic [DQ_W-1:0]    dq_s;
  logic               ck_q_ff;
  logic               ck_rise, ck_fall, cmd_sel;
  logic [3:0]         cmd_in;
  pwr_state_t         state_ff, nxt_state;
  logic               clk_on_ff, nxt_clk_on;
  logic [BANKS-1:0]   bank_ff, nxt_bank;
  logic               term_en_ff, nxt_term_en;
  logic               term_ctl_ff, nxt_term_ctl;
  logic               cmd_valid_ff, nxt_cmd_valid;
  logic [3:0]         cmd_ff, nxt_cmd;
  logic               wr_go_ff, nxt_wr_go;
  logic               rd_go_ff, nxt_rd_go;
  logic               term_on;

  // every pin crosses from the controller's timing through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {ck, clock_complement, cke, cs_n, ras_n, cas_n, we_n, ba,
                addr, termination_control, upper_write_mask,
                lower_write_mask, dqs_in, dq_in};
      s2_ff <= s1_ff;
    end
  end
  assign {ck_s, cn_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, addr_s, term_s,
          mask_s, dqs_s, dq_s} = s2_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ck_q_ff <= 1'h0;
    end else begin
      ck_q_ff <= ck_s;
    end
  end
  // sample point is the true clock rising while the complement is low
  assign ck_rise = ck_buf_en & ck_s & ~ck_q_ff & ~cn_s;
  assign ck_fall = ck_buf_en & ~ck_s & ck_q_ff;

  assign cmd_buf_en  = (state_ff == ST_ACTIVE);
  assign ck_buf_en   = (state_ff != ST_SELF_REF);
  assign term_buf_en = (state_ff != ST_SELF_REF);
  assign cmd_in  = {cs_s, ras_s, cas_s, we_s};
  assign cmd_sel = ck_rise & cmd_buf_en & ~cs_s;

  always_comb begin
    nxt_state     = state_ff;
    nxt_clk_on    = clk_on_ff;
    nxt_bank      = bank_ff;
    nxt_term_en   = term_en_ff;
    nxt_term_ctl  = term_ctl_ff;
    nxt_cmd_valid = 1'h0;
    nxt_cmd       = cmd_ff;
    nxt_wr_go     = 1'h0;
    nxt_rd_go     = 1'h0;
    unique case (state_ff)
      ST_ACTIVE: begin
        if (ck_rise) begin
          nxt_clk_on = cke_s;
          if (!cke_s) begin
            if (cmd_sel && cmd_in == CMD_REF && bank_ff == 4'h0) begin
              nxt_state = ST_SELF_REF;
            end else if (bank_ff == 4'h0) begin
              nxt_state = ST_PD_PRE;
            end else begin
              nxt_state = ST_PD_ACT;
            end
          end else if (cmd_sel) begin
            nxt_cmd_valid = 1'h1;
            nxt_cmd       = cmd_in;
            case (cmd_in)
              CMD_ACT: nxt_bank[ba_s] = 1'h1;
              CMD_PRE: begin
                if (addr_s[PRE_ALL_BIT]) begin
                  nxt_bank = 4'h0;
                end else begin
                  nxt_bank[ba_s] = 1'h0;
                end
              end
              CMD_WR: nxt_wr_go = 1'h1;
              CMD_RD: nxt_rd_go = 1'h1;
              CMD_LMR: begin
                if (ba_s == EMR_BANK) begin
                  nxt_term_en = addr_s[RTT_BIT0] | addr_s[RTT_BIT1];
                end
              end
              default: nxt_cmd = cmd_in;
            endcase
          end
        end
      end
      ST_PD_PRE, ST_PD_ACT: begin
        // power-down exit waits for a clock edge, never for cke alone
        if (ck_rise && cke_s) begin
          nxt_state  = ST_ACTIVE;
          nxt_clk_on = 1'h1;
        end
      end
      ST_SELF_REF: begin
        // the clock may be stopped here, so cke is watched by itself
        if (cke_s) begin
          nxt_state  = ST_ACTIVE;
          nxt_clk_on = 1'h1;
        end
      end
    endcase
    if (ck_rise) begin
      nxt_term_ctl = term_s;
    end
    if (nxt_state == ST_SELF_REF) begin
      nxt_term_ctl = 1'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // a powered-up part starts as if cke were held low
      state_ff     <= ST_PD_PRE;
      clk_on_ff    <= 1'h0;
      bank_ff      <= 4'h0;
      term_en_ff   <= TERM_RST;
      term_ctl_ff  <= 1'h0;
      cmd_valid_ff <= 1'h0;
      cmd_ff       <= CMD_NOP;
      wr_go_ff     <= 1'h0;
      rd_go_ff     <= 1'h0;
    end else begin
      state_ff     <= nxt_state;
      clk_on_ff    <= nxt_clk_on;
      bank_ff      <= nxt_bank;
      term_en_ff   <= nxt_term_en;
      term_ctl_ff  <= nxt_term_ctl;
      cmd_valid_ff <= nxt_cmd_valid;
      cmd_ff       <= nxt_cmd;
      wr_go_ff     <= nxt_wr_go;
      rd_go_ff     <= nxt_rd_go;
    end
  end

  assign term_on     = term_ctl_ff & term_en_ff;
  // only the 16 data, 2 strobe and 2 mask pins of this width terminate
  assign term_pin_en = {TERM_PINS{term_on}};
  assign pwr_state   = state_ff;
  assign clocking_on = clk_on_ff;
  assign cmd_valid   = cmd_valid_ff;
  assign cmd_code    = cmd_ff;
  assign bank_open   = bank_ff;

  ddr2_data_lane u_lane (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .wr_go      (wr_go_ff),
    .rd_go      (rd_go_ff),
    .ck_edge    (ck_rise | ck_fall),
    .buf_en     (cmd_buf_en),
    .dqs_s      (dqs_s),
    .dq_s       (dq_s),
    .mask_s     (mask_s),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .dqs_out    (dqs_out),
    .dqs_oe     (dqs_oe),
    .wr_data    (wr_data),
    .wr_byte_en (wr_byte_en),
    .wr_done    (wr_done)
  );

  a_clk_follows: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    ck_rise && state_ff == ST_ACTIVE |=> clk_on_ff == $past(cke_s))
    else $error("clocking does not follow registered cke");
  a_pd_idle: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    ck_rise && state_ff == ST_ACTIVE && !cke_s && bank_ff == 4'h0 &&
    !(cmd_sel && cmd_in == CMD_REF) |=> state_ff == ST_PD_PRE)
    else $error("idle banks did not give precharge power-down");
  a_pd_open: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    ck_rise && state_ff == ST_ACTIVE && !cke_s && bank_ff != 4'h0
    |=> state_ff == ST_PD_ACT ##1 state_ff == ST_PD_ACT || ck_rise)
    else $error("open row did not give active power-down");
  a_pd_sync: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (state_ff == ST_PD_PRE || state_ff == ST_PD_ACT) && !ck_rise
    |=> $stable(state_ff))
    else $error("power-down left without a clock edge");
  a_sr_exit: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    state_ff == ST_SELF_REF && cke_s |=> state_ff == ST_ACTIVE && clk_on_ff)
    else $error("self refresh exit missed");
  a_pd_buffers: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    state_ff == ST_PD_PRE || state_ff == ST_PD_ACT
    |-> !cmd_buf_en && ck_buf_en && term_buf_en)
    else $error("wrong buffers enabled in power-down");
  a_sr_buffers: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    state_ff == ST_SELF_REF |-> !ck_buf_en && !term_buf_en && !ck_rise &&
    term_pin_en == '0)
    else $error("buffers left on in self refresh");
  a_cs_masks: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    ck_rise && cs_s |=> !cmd_valid_ff && !wr_go_ff && !rd_go_ff)
    else $error("command decoded with chip select high");
  a_term_on: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    ck_rise && term_s && term_en_ff && !cmd_sel && cke_s &&
    state_ff == ST_ACTIVE |=> term_pin_en[0] && term_pin_en[19])
    else $error("termination not switched on");
  a_term_off: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !term_en_ff |-> term_pin_en == '0)
    else $error("termination control not ignored while disabled");
endmodule // ddr2_ctrl_pins
`default_nettype wire

// ### tb/host_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
  output logic        ck,
  output logic        clock_complement,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [1:0]  ba,
  output logic [12:0] addr,
  output logic        termination_control,
  output logic        lower_write_mask,
  output logic        upper_write_mask,
  output logic [15:0] dq_in,
  output logic [1:0]  dqs_in
);
  import ddr2_pins_pkg::*;
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 2'h0;
    addr = 13'h0000;
    termination_control = 1'b0;
    {upper_write_mask, lower_write_mask} = 2'h0;
    dq_in = 16'h0000;
    dqs_in = 2'h0;
  end
  // offset keeps the link clock unrelated in phase to ref_clk
  initial begin
    ck = 1'b0;
    clock_complement = 1'b1;
    #3;
    forever begin
      #80;
      ck = ~ck;
      clock_complement = ~clock_complement; // pair crosses together
    end
  end
  task automatic issue(input logic sel_n, input logic [3:0] code,
                       input logic [1:0] bank, input logic [12:0] a,
                       input logic ck_en);
    @(negedge ck);
    cke = ck_en; // moved at ck fall, sampled at the rise
    {cs_n, ras_n, cas_n, we_n} = {sel_n, code[2:0]}; // one code
    ba = bank;
    addr = a;
    @(posedge ck);
    @(negedge ck);
    cs_n = 1'b1; // idle deselected, one chip select per rank
    addr = ~a;
  endtask
  task automatic set_odt(input logic v);
    @(negedge ck);
    termination_control = v;
    @(posedge ck);
    @(negedge ck);
  endtask
  // exit self refresh between ck rises, no edge to sample it
  task automatic wake();
    @(posedge ck);
    #5;
    cke = 1'b1;
  endtask
  task automatic burst_write(input logic [63:0] d, input logic [7:0] m);
    issue(1'b0, CMD_WR, 2'h0, 13'h0000, 1'b1);
    for (int k = 0; k < BURST; k++) begin
      dq_in = d[k*16+:16];
      {upper_write_mask, lower_write_mask} = m[k*2+:2];
      #40;
      dqs_in = ~dqs_in; // strobe centred in the data eye
      #40;
    end
    dq_in = ~dq_in; // released bus shows no stale value
    {upper_write_mask, lower_write_mask} = 2'h3;
  endtask
endmodule // host_ctrl_model
`default_nettype wire

// ### tb/ddr2_ctrl_pins_test.sv
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_pins_test;
  import ddr2_pins_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ck, ckc, cke, cs_n, ras_n, cas_n, we_n, term_req, lo_mask, hi_mask;
  logic [1:0]  ba, dqs_in, dqs_out, dqs_oe;
  logic [12:0] addr;
  logic [15:0] dq_in, dq_out, dq_oe;
  pwr_state_t  pwr_state;
  logic        clocking_on, cmd_buf_en, ck_buf_en, term_buf_en;
  logic [19:0] term_pin_en;
  logic        cmd_valid, wr_done;
  logic [3:0]  cmd_code, bank_open;
  logic [63:0] wr_data;
  logic [7:0]  wr_byte_en;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int n_cmd = 0;
  int n_done = 0;
  int n0;
  always #5 ref_clk = ~ref_clk;
  host_ctrl_model u_host (.ck(ck), .clock_complement(ckc), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .termination_control(term_req), .lower_write_mask(lo_mask),
    .upper_write_mask(hi_mask), .dq_in(dq_in), .dqs_in(dqs_in));
  ddr2_ctrl_pins u_dut (.ref_clk(ref_clk), .nrst(nrst), .ck(ck),
    .clock_complement(ckc), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .termination_control(term_req), .lower_write_mask(lo_mask),
    .upper_write_mask(hi_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .pwr_state(pwr_state), .clocking_on(clocking_on),
    .cmd_buf_en(cmd_buf_en), .ck_buf_en(ck_buf_en),
    .term_buf_en(term_buf_en), .term_pin_en(term_pin_en),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .bank_open(bank_open),
    .wr_data(wr_data), .wr_byte_en(wr_byte_en), .wr_done(wr_done));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cmd_valid === 1'b1) n_cmd++;
    if (wr_done === 1'b1) n_done++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic t_power();
    check(pwr_state, ST_PD_PRE);
    check({clocking_on, cmd_buf_en, ck_buf_en}, 3'b001);
    check({cmd_code, bank_open}, {CMD_NOP, 4'h0});
    u_host.issue(1'b0, CMD_ACT, 2'h1, 13'h0000, 1'b0);
    check({n_cmd, bank_open}, {32'd0, 4'h0});
    u_host.issue(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b1);
    check({pwr_state, clocking_on, cmd_buf_en}, {ST_ACTIVE, 2'b11});
    n0 = n_cmd;
    u_host.issue(1'b1, CMD_ACT, 2'h2, 13'h0000, 1'b1);
    check({n_cmd, bank_open}, {n0, 4'h0});
    u_host.issue(1'b0, CMD_ACT, 2'h2, 13'h0000, 1'b1);
    check({n_cmd, cmd_code, bank_open}, {n0 + 1, CMD_ACT, 4'h4});
    u_host.issue(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b0);
    check({pwr_state, clocking_on}, {ST_PD_ACT, 1'b0});
    check({cmd_buf_en, ck_buf_en, term_buf_en}, 3'b011);
    u_host.issue(1'b0, CMD_PRE, 2'h0, 13'h0400, 1'b0);
    check(bank_open, 4'h4);
    u_host.issue(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b1);
    check(pwr_state, ST_ACTIVE);
    u_host.issue(1'b0, CMD_PRE, 2'h0, 13'h0400, 1'b1);
    check({cmd_code, bank_open}, {CMD_PRE, 4'h0});
    u_host.issue(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b0);
    check(pwr_state, ST_PD_PRE);
    u_host.issue(1'b1, CMD_NOP, 2'h0, 13'h0000, 1'b1);
  endtask
  task automatic t_term();
    u_host.set_odt(1'b1);
    check(term_pin_en, 20'h0_0000);
    u_host.issue(1'b0, CMD_LMR, 2'h1, 13'h0004, 1'b1);
    check(term_pin_en, 20'hF_FFFF);
    u_host.set_odt(1'b0);
    check(term_pin_en, 20'h0_0000);
    u_host.issue(1'b0, CMD_LMR, 2'h1, 13'h0040, 1'b1);
    u_host.set_odt(1'b1);
    check(term_pin_en, 20'hF_FFFF);
    u_host.issue(1'b0, CMD_LMR, 2'h1, 13'h0000, 1'b1);
    check(term_pin_en, 20'h0_0000);
    u_host.issue(1'b0, CMD_LMR, 2'h1, 13'h0004, 1'b1);
  endtask
  task automatic t_self_ref();
    u_host.issue(1'b0, CMD_REF, 2'h0, 13'h0000, 1'b0);
    check(pwr_state, ST_SELF_REF);
    check({cmd_buf_en, ck_buf_en, term_buf_en}, 3'b000);
    check(term_pin_en, 20'h0_0000);
    u_host.wake();
    repeat (6) @(negedge ref_clk);
    check(pwr_state, ST_ACTIVE);
  endtask
  task automatic t_data();
    logic [63:0] e;
    e = 64'hDDDD_33CC_BB22_AAAA;
    n0 = n_done;
    u_host.burst_write(64'h4444_3333_2222_1111, 8'h00);
    // the done pulse lands about 22 ns after the last strobe toggle
    repeat (2) @(negedge ref_clk);
    check({wr_data, wr_byte_en}, {64'h4444_3333_2222_1111, 8'hFF});
    check(n_done, n0 + 1);
    u_host.burst_write(64'hDDDD_CCCC_BBBB_AAAA, 8'h24);
    repeat (2) @(negedge ref_clk);
    check({wr_data, wr_byte_en}, {e, 8'hDB});
    check(n_done, n0 + 2);
    u_host.issue(1'b0, CMD_RD, 2'h0, 13'h0000, 1'b1);
    #60;
    for (int k = 0; k < BURST; k++) begin
      check({dq_out, dq_oe}, {e[k*16+:16], 16'hFFFF});
      check({dqs_out, dqs_oe}, {k[0] ? 2'b00 : 2'b11, 2'b11});
      #80;
    end
    check({dq_oe, dqs_oe}, 18'h0_0000);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    t_power();
    t_term();
    t_self_ref();
    t_data();
    print_verdict();
  end
endmodule // ddr2_ctrl_pins_test
`default_nettype wire
